// ### src/identify_words_defines.vh
// Constants for the identify-data word generator, words 49 to 81.
// Assumes inclusion by bare name from the design file; definitions only.
//
// Functional notes
// - Identify sector carries these words at fixed positions
// - Word 49 reports flow control, LBA, DMA
// - Word 50 valid marker, standby minimum below five
// - Word 53 validity bits and free-fall sensitivity
// - Words 54-56 report current translation geometry
// - Words 57-58 current capacity, low word first
// - Word 59 multiple-sector count with valid bit
// - Words 60-61 user sectors, saturated when large
// - Words 51-52 legacy constant, word 62 zero
// - Word 63 supports MDMA 0-2, active mode high
// - Word 64 advanced PIO modes 3 and 4
// - Words 65-68 report 120 ns cycle times
// - Word 75 queue depth minus one is 31
// - Word 76 SATA capability bits, Gen-2 selectable
// - Word 78 supported SATA features fixed 005E
// - Word 79 enabled features, default 0040
// - Word 80 major version bitmap
// - Word 81 minor version code
`ifndef IDENTIFY_WORDS_DEFINES_VH
`define IDENTIFY_WORDS_DEFINES_VH

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define A_WORD_SEL 12'h000
`define A_WORD_DATA 12'h004
`define A_GEOMETRY 12'h008
`define A_SECTORS 12'h00C
`define A_CAPACITY 12'h010
`define A_USER_SECT 12'h014
`define A_MODES 12'h018
`define A_SATA_EN 12'h01C
`define ADDR_W 12

// ----------------------------------------------------------------
// Word positions inside the sector
// ----------------------------------------------------------------
`define W_CAPAB 8'h31
`define W_CAPAB2 8'h32
`define W_PIO_LEG 8'h33
`define W_DMA_LEG 8'h34
`define W_VALID 8'h35
`define W_CYL 8'h36
`define W_HEADS 8'h37
`define W_SPT 8'h38
`define W_CAP_LO 8'h39
`define W_CAP_HI 8'h3A
`define W_MULT 8'h3B
`define W_USR_LO 8'h3C
`define W_USR_HI 8'h3D
`define W_DMA1 8'h3E
`define W_MDMA 8'h3F
`define W_PIO_ADV 8'h40
`define W_T_FIRST 8'h41
`define W_T_LAST 8'h44
`define W_QDEPTH 8'h4B
`define W_SATA_CAP 8'h4C
`define W_SATA_SUP 8'h4E
`define W_SATA_EN 8'h4F
`define W_MAJOR 8'h50
`define W_MINOR 8'h51

// ----------------------------------------------------------------
// Fixed word contents
// ----------------------------------------------------------------
`define V_CAPAB 16'h0F00
`define B_STBY_STD 13
`define V_CAPAB2 16'h4000
`define V_LEGACY 16'h0200
`define V_VALID 16'h0007
`define V_MULT_OK 8'h01
`define V_MDMA_SUP 8'h07
`define V_PIO_ADV 16'h0003
`define V_CYCLE_NS 16'h0078
`define V_QDEPTH 16'h001F
`define V_SATA_CAP 16'h1702
`define B_GEN2 2
`define V_SATA_SUP 16'h005E
`define V_SATA_EN_RST 16'h0040
`define V_MAJOR 16'h01FC
`define V_MINOR 16'h0029
`define V_ZERO 16'h0000
`define V_SAT32 32'h0FFFFFFF
`define V_SAT48 48'h00000FFFFFFF

// ----------------------------------------------------------------
// Reset values of the configuration registers
// ----------------------------------------------------------------
`define R_GEOMETRY 32'h0010_3FFF
`define R_SECTORS 32'h0000_003F
`define R_MODES 32'h0000_0000

`endif

// ### src/identify_words.v
// Identify-data word generator for words 49 to 81 of the identify sector.
// Assumes an APB master on the same clock; the sector transport reads
// the word select and data registers, or the streaming word port.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "identify_words_defines.vh"

module identify_words (
    input wire I_REF_CLK,              // 250 MHz clock
    input wire I_SYS_RST,              // Async reset, active high
    input wire I_PSEL,                 // APB select
    input wire I_PENABLE,              // APB access phase
    input wire I_PWRITE,               // APB write
    input wire [11:0] I_PADDR,         // APB byte address
    input wire [31:0] I_PWDATA,        // APB write data
    input wire [7:0] I_WORD_IDX,       // Sector word index to assemble
    output reg [31:0] O_PRDATA,        // APB read data
    output reg O_PREADY,               // APB ready
    output reg O_PSLVERR,              // APB error, unmapped address
    output reg [15:0] O_WORD           // Assembled word for I_WORD_IDX
);

// ----------------------------------------------------------------
// Configuration state
// ----------------------------------------------------------------
reg [7:0] word_sel;
reg [31:0] geometry;      // [15:0] cylinders, [23:16] heads
reg [31:0] sectors;       // [7:0] per track, [15:8] multiple, [16] valid
reg [31:0] capacity;
reg [47:0] user_sectors;
reg [31:0] modes;         // [7:0] MDMA active, [8] gen2, [9] std standby
reg [15:0] sata_en;
reg [15:0] sel_word;

wire access = I_PSEL && I_PENABLE;
wire wr = access && I_PWRITE;

// Word generator, shared by APB read path and streaming port
function [15:0] word_of;
    input [7:0] idx;
    reg [15:0] w;
    begin
        w = `V_ZERO;
        case (idx)
            `W_CAPAB: begin
                w = `V_CAPAB;
                w[`B_STBY_STD] = modes[9];
            end
            `W_CAPAB2: w = `V_CAPAB2;
            `W_PIO_LEG: w = `V_LEGACY;
            `W_DMA_LEG: w = `V_LEGACY;
            `W_VALID: w = `V_VALID;
            `W_CYL: w = geometry[15:0];
            `W_HEADS: w = {8'h00, geometry[23:16]};
            `W_SPT: w = {8'h00, sectors[7:0]};
            `W_CAP_LO: w = capacity[15:0];
            `W_CAP_HI: w = capacity[31:16];
            `W_MULT: w = {7'h00, sectors[16], sectors[15:8]};
            `W_USR_LO: w = user_lo(user_sectors);
            `W_USR_HI: w = user_hi(user_sectors);
            `W_DMA1: w = `V_ZERO;
            `W_MDMA: w = {modes[7:0], `V_MDMA_SUP};
            `W_PIO_ADV: w = `V_PIO_ADV;
            `W_QDEPTH: w = `V_QDEPTH;
            `W_SATA_CAP: begin
                w = `V_SATA_CAP;
                w[`B_GEN2] = modes[8];
            end
            `W_SATA_SUP: w = `V_SATA_SUP;
            `W_SATA_EN: w = sata_en & `V_SATA_SUP;
            `W_MAJOR: w = `V_MAJOR;
            `W_MINOR: w = `V_MINOR;
            default: begin
                // Timing words, else reserved or outside this range
                if (idx >= `W_T_FIRST && idx <= `W_T_LAST)
                    w = `V_CYCLE_NS;
                else
                    w = `V_ZERO;
            end
        endcase
        word_of = w;
    end
endfunction

// ----------------------------------------------------------------
// Capacity saturation
// ----------------------------------------------------------------
// Large drives report the clamp, 48-bit count is elsewhere in the sector
function [31:0] user_sat;
    input [47:0] n;
    begin
        if (n > `V_SAT48)
            user_sat = `V_SAT32;
        else
            user_sat = n[31:0];
    end
endfunction

function [15:0] user_lo;
    input [47:0] n;
    reg [31:0] s;
    begin
        s = user_sat(n);
        user_lo = s[15:0];
    end
endfunction

function [15:0] user_hi;
    input [47:0] n;
    reg [31:0] s;
    begin
        s = user_sat(n);
        user_hi = s[31:16];
    end
endfunction

// ----------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------
always @* begin
    sel_word = word_of(word_sel);
end

always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
        word_sel <= 8'h00;
        geometry <= `R_GEOMETRY;
        sectors <= `R_SECTORS;
        capacity <= 32'h0000_0000;
        user_sectors <= 48'h0000_0000_0000;
        modes <= `R_MODES;
        sata_en <= `V_SATA_EN_RST;
        O_PRDATA <= 32'h0000_0000;
        O_PREADY <= 1'b0;
        O_PSLVERR <= 1'b0;
        O_WORD <= 16'h0000;
    end else begin
        // Word sampled from live state every cycle
        O_WORD <= word_of(I_WORD_IDX);
        // One wait state: ready rises in the second access cycle
        O_PREADY <= access && !O_PREADY;
        O_PSLVERR <= 1'b0;
        O_PRDATA <= 32'h0000_0000;
        if (access && !O_PREADY) begin
            case (I_PADDR)
                `A_WORD_SEL: begin
                    if (I_PWRITE)
                        word_sel <= I_PWDATA[7:0];
                    O_PRDATA <= {24'h000000, word_sel};
                end
                `A_WORD_DATA: O_PRDATA <= {16'h0000, sel_word};
                `A_GEOMETRY: begin
                    if (I_PWRITE)
                        geometry <= {8'h00, I_PWDATA[23:0]};
                    O_PRDATA <= geometry;
                end
                `A_SECTORS: begin
                    if (I_PWRITE)
                        sectors <= {15'h0000, I_PWDATA[16:0]};
                    O_PRDATA <= sectors;
                end
                `A_CAPACITY: begin
                    if (I_PWRITE)
                        capacity <= I_PWDATA;
                    O_PRDATA <= capacity;
                end
                `A_USER_SECT: begin
                    // Write shifts in 32 bits: upper word first, then lower
                    if (I_PWRITE)
                        user_sectors <= {user_sectors[15:0], I_PWDATA};
                    O_PRDATA <= user_sat(user_sectors);
                end
                `A_MODES: begin
                    if (I_PWRITE)
                        modes <= {22'h000000, I_PWDATA[9:0]};
                    O_PRDATA <= modes;
                end
                `A_SATA_EN: begin
                    if (I_PWRITE)
                        sata_en <= I_PWDATA[15:0] & `V_SATA_SUP;
                    O_PRDATA <= {16'h0000, sata_en};
                end
                default: O_PSLVERR <= 1'b1;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// ### test/identify_words_properties.sv
// Checker for the identify word generator, words 49 to 81.
// Assumes it is bound to identify_words and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module identify_words_properties (
    input wire logic I_REF_CLK, // Clock
    input wire logic I_SYS_RST, // Async reset
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB access
    input wire logic [7:0] I_WORD_IDX, // Word index
    input wire logic O_PREADY, // APB ready
    input wire logic O_PSLVERR, // APB error
    input wire logic [15:0] O_WORD // Word out
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ----------------------------------------
    // Word contents, one cycle after the index
    // ----------------------------------------
    // First edge after reset sees a stale index, hence the guard
    property p_w(int n, logic [15:0] m, logic [15:0] v);
        !$past(I_SYS_RST) && $past(I_WORD_IDX) == n |-> (O_WORD & m) == v;
    endproperty
    a_capab_fixed: assert property (p_w(49, 16'hDFFF, 16'h0F00)) else $error("word 49 wrong");
    a_valid_word: assert property (p_w(50, 16'hFFFF, 16'h4000)) else $error("word 50 wrong");
    a_legacy_mode: assert property (p_w(52, 16'hFFFF, 16'h0200)) else $error("word 52 wrong");
    a_field_valid: assert property (p_w(53, 16'hFFFF, 16'h0007)) else $error("word 53 wrong");
    a_mult_rsvd: assert property (p_w(59, 16'hFE00, 16'h0000)) else $error("word 59 wrong");
    a_dma_modes: assert property (p_w(63, 16'h00FF, 16'h0007)) else $error("word 63 wrong");
    a_pio_adv: assert property (p_w(64, 16'hFFFF, 16'h0003)) else $error("word 64 wrong");
    a_cycle_time: assert property (p_w(67, 16'hFFFF, 16'h0078)) else $error("word 67 wrong");
    a_queue_depth: assert property (p_w(75, 16'hFFFF, 16'h001F)) else $error("word 75 wrong");
    a_sata_cap: assert property (p_w(76, 16'hFFFB, 16'h1702)) else $error("word 76 wrong");
    a_sata_sup: assert property (p_w(78, 16'hFFFF, 16'h005E)) else $error("word 78 wrong");
    a_enab_rsvd: assert property (p_w(79, 16'hFFA1, 16'h0000)) else $error("word 79 wrong");
    a_major_ver: assert property (p_w(80, 16'hFFFF, 16'h01FC)) else $error("word 80 wrong");
    a_minor_ver: assert property (p_w(81, 16'hFFFF, 16'h0029)) else $error("word 81 wrong");
    a_rsvd_zero: assert property (!$past(I_SYS_RST) && $past(I_WORD_IDX) inside {[69:74], 77} |-> O_WORD == 0)
        else $error("reserved word not zero");
    a_one_wait: assert property (I_PSEL && $rose(I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
        else $error("apb wait state wrong");
    cover property ($past(I_WORD_IDX) == 8'h3D && O_WORD == 16'h0FFF);
    cover property (O_PREADY && O_PSLVERR);
    cover property ($past(I_WORD_IDX) == 8'h31 && O_WORD[13]);
endmodule
`default_nettype wire

// ### test/sector_host.sv
// Host-side reader that walks the sector word index across 48 to 82.
// Assumes one clock shared with the word generator.
`timescale 1ns/1ps
`default_nettype none
module sector_host (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset
    input wire logic go, // Start one pass
    output logic [7:0] idx // Word index
);
    initial idx = 8'h00;
    // Index parks at zero between passes, a word outside the block
    always @(posedge clk or posedge rst) begin
        if (rst) idx <= 8'h00;
        else if (go) idx <= 8'h30;
        else if (idx != 8'h00 && idx < 8'h52) idx <= idx + 8'h01;
        else idx <= 8'h00;
    end
endmodule
`default_nettype wire

// ### test/identify_words_tb_top.sv
// Testbench for identify_words: APB configuration, sector passes, model compare.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "identify_words_defines.vh"
module identify_words_tb_top;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, lo, cap = 0;
    logic [15:0] word, hi, cyl = 16'h3FFF, hd = 16'h0010, spt = 16'h003F, mo = 0, en = 16'h0040;
    logic [7:0] idx;
    logic [8:0] mul = 0;
    logic [47:0] us = 0;
    int num_errors = 0, check_count = 0;
    always #2 clk = ~clk;
    identify_words identify_words_inst (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_WORD_IDX(idx), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_WORD(word));
    sector_host sector_host_inst (.clk(clk), .rst(rst), .go(go), .idx(idx));
    // ----------------------------------------
    // Model and checks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function logic [15:0] ex(input int n);
        logic [31:0] s;
        s = us > 48'h0FFFFFFF ? 32'h0FFFFFFF : us[31:0];
        case (n)
            49: ex = 16'h0F00 | {mo[9], 13'h0000};
            50: ex = 16'h4000;
            51, 52: ex = 16'h0200;
            53: ex = 16'h0007;
            54: ex = cyl;
            55: ex = hd;
            56: ex = spt;
            57: ex = cap[15:0];
            58: ex = cap[31:16];
            59: ex = {7'h00, mul};
            60: ex = s[15:0];
            61: ex = s[31:16];
            63: ex = {mo[7:0], 8'h07};
            64: ex = 16'h0003;
            65, 66, 67, 68: ex = 16'h0078;
            75: ex = 16'h001F;
            76: ex = 16'h1702 | {mo[8], 2'h0};
            78: ex = 16'h005E;
            79: ex = en & 16'h005E;
            80: ex = 16'h01FC;
            81: ex = 16'h0029;
            default: ex = 16'h0000;
        endcase
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sector;
        int k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (36) begin
            @(posedge clk);
            k = idx;
            #1 chk(word, ex(k));
        end
    endtask
    task results;
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        void'($urandom(64366));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        sector;
        apb(1'b1, `A_WORD_SEL, 32'h0000004F);
        apb(1'b0, `A_WORD_DATA, 32'h00000000);
        chk(rd, {16'h0000, ex(79)});
        apb(1'b0, 12'h020, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        for (int r = 0; r < 2; r++) begin
            lo = $urandom & 32'h00FFFFFF;
            cyl = lo[15:0];
            hd = {8'h00, lo[23:16]};
            apb(1'b1, `A_GEOMETRY, lo);
            apb(1'b0, `A_GEOMETRY, 32'h00000000);
            chk(rd, {8'h00, hd[7:0], cyl});
            lo = $urandom & 32'h0001FFFF;
            spt = {8'h00, lo[7:0]};
            mul = lo[16:8];
            apb(1'b1, `A_SECTORS, lo);
            cap = $urandom;
            apb(1'b1, `A_CAPACITY, cap);
            // Upper part first, the lower write completes the count
            hi = r ? 16'($urandom | 1) : 16'h0000;
            lo = $urandom >> (r ? 0 : 4);
            us = {hi, lo};
            apb(1'b1, `A_USER_SECT, {16'h0000, hi});
            apb(1'b1, `A_USER_SECT, lo);
            apb(1'b0, `A_USER_SECT, 32'h00000000);
            chk(rd, {ex(61), ex(60)});
            mo = $urandom & 16'h03FF;
            apb(1'b1, `A_MODES, {16'h0000, mo});
            lo = $urandom;
            en = lo[15:0];
            apb(1'b1, `A_SATA_EN, lo);
            sector;
        end
        results;
    end
    initial begin
        #100000;
        num_errors++;
        results;
    end
endmodule
bind identify_words identify_words_properties identify_words_properties_inst (.I_REF_CLK(I_REF_CLK),
    .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_WORD_IDX(I_WORD_IDX),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_WORD(O_WORD));
`default_nettype wire
